// ### hdl/wdt_pkg.sv
// constants, register map and carrier types for the watchdog timer
// assumes a 50 MHz system clock and a word-wide wishbone slave port
package wdt_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADR_W = 18;
  localparam logic [15:0] IDX_CONTROL = 16'hF020;
  localparam logic [15:0] IDX_PRESC_VALUE = 16'hF021;
  localparam logic [15:0] IDX_PRESC_WRAP = 16'hF022;
  localparam logic [15:0] IDX_COUNTDOWN = 16'hF023;
  localparam logic [15:0] IDX_TRIG_STATUS = 16'hF024;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hF025;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'hF026;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF027;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PRESC_W = 16;
  localparam int COUNT_W = 12;
  localparam int IRQ_W = 2;
  localparam int CTRL_W = 2;
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam int CTRL_TRIGGER_EN_BIT = 1;
  localparam int STATUS_TRIGGERED_BIT = 0;
  localparam int IRQ_EXPIRED_BIT = 0;
  localparam int IRQ_WRAP_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 16'h0000;
  localparam logic [PRESC_W-1:0] WRAP_RESET = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 12'hFFF;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_PULSE_NS = 320;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = $clog2(RESET_PULSE_CYC + 1);

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic trigger_en;
    logic count_en;
  } wdt_ctrl_s;

  typedef struct packed {
    logic wrap;
    logic expired;
  } wdt_irq_s;

endpackage

// ### hdl/wdt_edge_sync.sv
// two-flop synchroniser with rising-edge detector for a pin input
// assumes the pin toggles slower than half the system clock rate
module wdt_edge_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic rise_out
);

  logic meta;
  logic stable;
  logic stable_d;

  // the first stage feeds only the second; the detector looks later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      stable_d <= stable;
    end
  end

  assign rise_out = stable & ~stable_d;

endmodule

// ### hdl/wdt_timer.sv
// watchdog timer: oscillator-driven prescaler, 12-bit countdown,
// chip-reset pulse, sticky trigger flag and interrupt registers
// assumes a classic wishbone master on mclk_in and a separate
// power-on reset that is distinct from the chip reset it drives

// Functional notes
// R1: after reset the countdown is stopped and the chip reset disarmed.
// R2: control bit 0 lets the countdown advance; resets to 0.
// R3: control bit 1 arms the chip reset on zero; resets to 0.
// R4: counting without arming runs the countdown but never resets chip.
// R5: 16-bit prescaler counts oscillator pin edges, readable read-only.
// R6: prescaler equal to wrap setting returns to zero and steps countdown.
// R7: oscillator divided by wrap setting plus one; wrap resets to FFFF.
// R8: 12-bit read-write countdown, resets to FFF, one step per wrap.
// R9: countdown at zero while armed asserts a whole-chip reset.
// R10: a software write to the countdown loads a new time-out count.
// R11: software must rewrite the countdown before it reaches zero.
// R12: status bit 0 reads 1 once the watchdog fired, read-only.
// R13: trigger flag survives chip reset, cleared only by power-on reset.
// R14: prescaler and countdown timed by oscillator pin, not the pll.
// R15: disarmed countdown holds at zero until software writes it.
module wdt_timer (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic por_rst_in,
  input wire logic oscillator_input_pin_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [wdt_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic chip_reset_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic rst;
  logic osc_edge;
  logic wb_ack;
  logic [31:0] rd_data;
  wdt_pkg::wdt_ctrl_s ctrl;
  logic [wdt_pkg::PRESC_W-1:0] presc;
  logic [wdt_pkg::PRESC_W-1:0] wrap;
  logic [wdt_pkg::COUNT_W-1:0] count;
  logic triggered;
  logic [wdt_pkg::PULSE_CNT_W-1:0] pulse_cnt;
  wdt_pkg::wdt_irq_s irq_status;
  wdt_pkg::wdt_irq_s irq_enable;
  wdt_pkg::wdt_irq_s irq_event;
  wdt_pkg::wdt_irq_s irq_clear;

  // power-on reset implies a system reset for everything not sticky
  assign rst = sys_rst_in | por_rst_in;

  // ----------------------------------------------------------------
  // oscillator pin crossing
  // ----------------------------------------------------------------
  // counting synchronised edges keeps the timebase tied to the crystal
  // and not to the pll; the pin must stay below 25 MHz
  wdt_edge_sync u_osc_sync (
    .clk_in(mclk_in),
    .rst_in(rst),
    .async_in(oscillator_input_pin_in),
    .rise_out(osc_edge) // see R14
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic hit_ctrl;
  logic hit_presc;
  logic hit_wrap;
  logic hit_count;
  logic hit_trig;
  logic hit_irq_status;
  logic hit_irq_clear;
  logic hit_irq_enable;

  assign req = wb_cyc_in & wb_stb_in & ~wb_ack;
  assign wr = req & wb_we_in;
  assign rd = req & ~wb_we_in;
  assign idx = wb_adr_in[wdt_pkg::ADR_W-1:2];
  assign hit_ctrl = idx == wdt_pkg::IDX_CONTROL;
  assign hit_presc = idx == wdt_pkg::IDX_PRESC_VALUE;
  assign hit_wrap = idx == wdt_pkg::IDX_PRESC_WRAP;
  assign hit_count = idx == wdt_pkg::IDX_COUNTDOWN;
  assign hit_trig = idx == wdt_pkg::IDX_TRIG_STATUS;
  assign hit_irq_status = idx == wdt_pkg::IDX_IRQ_STATUS;
  assign hit_irq_clear = idx == wdt_pkg::IDX_IRQ_CLEAR;
  assign hit_irq_enable = idx == wdt_pkg::IDX_IRQ_ENABLE;

  // byte-lane merge: lanes without a select keep the old contents
  function automatic logic [31:0] merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] wrap_word;
  logic [31:0] count_word;
  logic [31:0] enable_word;
  logic [31:0] clear_word;

  assign ctrl_word = merge({30'h0, ctrl}, wb_dat_in, wb_sel_in);
  assign wrap_word = merge({16'h0, wrap}, wb_dat_in, wb_sel_in);
  assign count_word = merge({20'h0, count}, wb_dat_in, wb_sel_in);
  assign enable_word = merge({30'h0, irq_enable}, wb_dat_in, wb_sel_in);
  assign clear_word = merge(32'h0, wb_dat_in, wb_sel_in);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      ctrl <= wdt_pkg::CTRL_RESET; // see R1
    end else if (wr && hit_ctrl) begin
      ctrl.count_en <= ctrl_word[wdt_pkg::CTRL_COUNT_EN_BIT]; // see R2
      ctrl.trigger_en <= ctrl_word[wdt_pkg::CTRL_TRIGGER_EN_BIT]; // see R3
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic wrap_tick;

  assign wrap_tick = osc_edge & (presc == wrap); // see R6

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      wrap <= wdt_pkg::WRAP_RESET; // see R7
    end else if (wr && hit_wrap) begin
      wrap <= wrap_word[wdt_pkg::PRESC_W-1:0];
    end
  end

  // a wrap setting written below the current value is passed by once
  // the prescaler rolls over from all ones, with no step on that lap
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      presc <= wdt_pkg::PRESC_RESET;
    end else if (wrap_tick) begin
      presc <= wdt_pkg::PRESC_RESET; // see R6, R7
    end else if (osc_edge) begin
      presc <= presc + 1'b1; // see R5
    end
  end

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  logic count_write;
  logic count_step;

  assign count_write = wr & hit_count;
  // at zero the count stops instead of wrapping, armed or not
  assign count_step = wrap_tick & ctrl.count_en & (count != '0) &
    ~count_write; // see R2, R8, R15

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      count <= wdt_pkg::COUNT_RESET; // see R8
    end else if (count_write) begin
      count <= count_word[wdt_pkg::COUNT_W-1:0]; // see R10
    end else if (count_step) begin
      count <= count - 1'b1; // see R8
    end
  end

  // ----------------------------------------------------------------
  // chip reset and trigger flag
  // ----------------------------------------------------------------
  logic fire;

  // firing repeats while the count stays at zero and armed, so a chip
  // reset that is not looped back to sys_rst_in still keeps pulsing
  assign fire = ~rst & ctrl.trigger_en & (count == '0) &
    (pulse_cnt == '0); // see R3, R4, R9

  // the pulse counter answers only to power-on reset so that the chip
  // reset it drives cannot cut its own pulse short
  always_ff @(posedge mclk_in) begin
    if (por_rst_in) begin
      pulse_cnt <= '0;
    end else if (fire) begin
      pulse_cnt <= wdt_pkg::PULSE_CNT_W'(wdt_pkg::RESET_PULSE_CYC); // see R9
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  assign chip_reset_out = pulse_cnt != '0; // see R9

  always_ff @(posedge mclk_in) begin
    if (por_rst_in) begin
      triggered <= 1'b0; // see R13
    end else if (fire) begin
      triggered <= 1'b1; // see R12
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_event.expired = count_step & (count == 12'h001);
  assign irq_event.wrap = wrap_tick;
  assign irq_clear = (wr && hit_irq_clear) ?
    clear_word[wdt_pkg::IRQ_W-1:0] : wdt_pkg::IRQ_RESET;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      irq_status <= wdt_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      irq_enable <= wdt_pkg::IRQ_RESET;
    end else if (wr && hit_irq_enable) begin
      irq_enable <= enable_word[wdt_pkg::IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // read back and acknowledge
  // ----------------------------------------------------------------
  // unmapped indices and reserved bits read as zero; writes to
  // read-only registers are acknowledged and dropped
  always_comb begin
    rd_data = 32'h0;
    unique case (1'b1)
      hit_ctrl: rd_data = {30'h0, ctrl};
      hit_presc: rd_data = {16'h0, presc}; // see R5
      hit_wrap: rd_data = {16'h0, wrap};
      hit_count: rd_data = {20'h0, count};
      hit_trig: rd_data = {31'h0, triggered}; // see R12
      hit_irq_status: rd_data = {30'h0, irq_status};
      hit_irq_enable: rd_data = {30'h0, irq_enable};
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= req;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      wb_dat_out <= 32'h0;
    end else if (rd) begin
      wb_dat_out <= rd_data;
    end
  end

  assign wb_ack_out = wb_ack;

endmodule

// ### tb/wdt_timer_assertions.sv
// bus and chip-reset timing checks for the watchdog timer
// assumes it is bound to wdt_timer and sees its ports only
module wdt_timer_checker (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic por_rst_in,
  input wire logic oscillator_input_pin_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [wdt_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic chip_reset_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in || por_rst_in);
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd_of(logic [15:0] i);
    wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in[17:2]) == i;
  endsequence
  sequence s_pulse;
    chip_reset_out [*8] ##1 chip_reset_out [*8] ##1 !chip_reset_out;
  endsequence
  property p_ack_once;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_follows;
    s_take |=> wb_ack_out;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack");
  property p_ack_cause;
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_hold;
    !(wb_ack_out && !$past(wb_we_in)) |-> $stable(wb_dat_out);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data moved");
  property p_upper_zero;
    wb_ack_out |-> wb_dat_out[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper set");
  property p_unmapped;
    wb_ack_out && !$past(wb_we_in) &&
      ($past(wb_adr_in[17:2]) > wdt_pkg::IDX_IRQ_ENABLE ||
       $past(wb_adr_in[17:2]) < wdt_pkg::IDX_CONTROL)
      |-> wb_dat_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_ctrl_w;
    s_rd_of(wdt_pkg::IDX_CONTROL) |-> wb_dat_out[31:2] == 30'h0;
  endproperty
  a_ctrl_w: assert property (p_ctrl_w) else $error("control width");
  property p_count_w;
    s_rd_of(wdt_pkg::IDX_COUNTDOWN) |-> wb_dat_out[31:12] == 20'h0;
  endproperty
  a_count_w: assert property (p_count_w) else $error("count width");
  property p_pulse;
    $rose(chip_reset_out) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
endmodule

// ### tb/test_watchdog_timer.sv
// self-checking bench for the watchdog timer over classic wishbone
// assumes the oscillator pin is slow enough for the 3-cycle sync path
module test_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, por = 1, pin = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] sel = 4'h0;
  logic [17:0] adr = 18'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic ack, crst, irq;
  int fails = 0, checks = 0, cnt = 0;
  logic [15:0] ridx [9] = '{16'hF020, 16'hF021, 16'hF022, 16'hF023,
    16'hF024, 16'hF025, 16'hF026, 16'hF027, 16'hF028};
  logic [31:0] rexp [9] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFF, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0};
  wdt_timer wdt_timer_i (.mclk_in(clk), .sys_rst_in(rst), .por_rst_in(por),
    .oscillator_input_pin_in(pin), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(wd),
    .wb_dat_out(rd), .wb_ack_out(ack), .chip_reset_out(crst),
    .irq_out(irq));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cnt++;
    if (cnt == 8000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle; the leading edge gives the idle cycle between calls
  task automatic wb(input logic [15:0] i, input logic w,
      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; wd <= d; sel <= s;
    // no cycle count is assumed; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 0; stb <= 0;
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] i,
      input logic [31:0] e);
    wb(i, 0, 32'h0, 4'hF);
    chk(nm, q, e);
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clk) pin <= 1;
      repeat (3) @(posedge clk);
      pin <= 0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_rst(input logic p);
    @(posedge clk) begin rst <= 1; por <= p; end
    repeat (5) @(posedge clk);
    rst <= 0; por <= 0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0; por <= 0;
    for (int k = 0; k < 9; k++) begin
      rd_chk("reset row", ridx[k], rexp[k]);
    end
    wb(16'hF021, 1, 32'h1234, 4'hF);
    wb(16'hF024, 1, 32'h1, 4'hF);
    rd_chk("ro presc", 16'hF021, 32'h0);
    rd_chk("ro status", 16'hF024, 32'h0);
    wb(16'hF022, 1, 32'h3, 4'hF);
    osc(2);
    rd_chk("presc", 16'hF021, 32'h2);
    osc(2);
    rd_chk("presc wrap", 16'hF021, 32'h0);
    rd_chk("gated", 16'hF023, 32'hFFF);
    wb(16'hF022, 1, 32'h1, 4'hF);
    wb(16'hF023, 1, 32'h3, 4'hF);
    wb(16'hF020, 1, 32'h1, 4'hF);
    osc(4);
    rd_chk("count", 16'hF023, 32'h1);
    osc(4);
    rd_chk("hold zero", 16'hF023, 32'h0);
    chk("count only", {31'h0, crst}, 32'h0);
    rd_chk("irq status", 16'hF025, 32'h3);
    wb(16'hF027, 1, 32'h1, 4'hF);
    chk("irq on", {31'h0, irq}, 32'h1);
    wb(16'hF027, 1, 32'h0, 4'hF);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wb(16'hF027, 1, 32'h1, 4'hF);
    wb(16'hF026, 1, 32'h1, 4'hF);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk("irq left", 16'hF025, 32'h2);
    wb(16'hF020, 1, 32'h3, 4'hF);
    repeat (3) @(posedge clk);
    chk("fire", {31'h0, crst}, 32'h1);
    rd_chk("triggered", 16'hF024, 32'h1);
    pulse_rst(0);
    rd_chk("kept", 16'hF024, 32'h1);
    rd_chk("disarmed", 16'hF020, 32'h0);
    pulse_rst(1);
    rd_chk("por clear", 16'hF024, 32'h0);
    wb(16'hF023, 1, 32'h0AB, 4'h1);
    rd_chk("byte load", 16'hF023, 32'hFAB);
    stop_test();
  end
endmodule
bind wdt_timer wdt_timer_checker chk_i (.mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in), .por_rst_in(por_rst_in),
  .oscillator_input_pin_in(oscillator_input_pin_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .chip_reset_out(chip_reset_out), .irq_out(irq_out));
